// ===== src/atsiw_edge.sv
// Purpose: Rise and fall detection for a vector of levels
// Assumes: Inputs synchronous to aclk
// Notes:   One cycle pulses, combinational from the held copy
`timescale 1ns/10ps
`default_nettype none
module atsiw_edge #(
    parameter int W = 6
) (
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Levels and edges
    input  wire logic [W-1:0] level,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);

    logic [W-1:0] prev_q;
    logic         armed_q;

    // No edges until the held copy is valid: a level already high
    // at reset release must not look like a rise
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            prev_q  <= '0;
            armed_q <= 1'b0;
        end
        else
        begin
            prev_q  <= level;
            armed_q <= 1'b1;
        end
    end

    assign rise = level & ~prev_q & {W{armed_q}};
    assign fall = prev_q & ~level & {W{armed_q}};

endmodule
`default_nettype wire

// ===== src/atsiw_flags.sv
// Purpose: Bank of sticky flags with per-bit set and clear
// Assumes: Set and clear are one cycle strobes
// Notes:   A set in the clearing cycle wins, so no event is lost
`timescale 1ns/10ps
`default_nettype none
module atsiw_flags #(
    parameter int W = 32
) (
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Strobes
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    // State
    output logic      [W-1:0] flags
);

    logic [W-1:0] flags_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            flags_q <= '0;
        else
            flags_q <= set | (flags_q & ~clr);
    end

    assign flags = flags_q;

endmodule
`default_nettype wire

// ===== src/atsiw_pkg.sv
// Purpose: Shared types of the timer status block
// Assumes: Nothing
// Notes:   Offsets live in atsiw_regs.svh
package atsiw_pkg;

    typedef enum logic [3:0] {
        ATSIW_SEL_NONE,
        ATSIW_SEL_CONTROL,
        ATSIW_SEL_COUNTER,
        ATSIW_SEL_STATUS,
        ATSIW_SEL_STAT_CLR,
        ATSIW_SEL_IRQ_SET,
        ATSIW_SEL_IRQ_CLR,
        ATSIW_SEL_IRQ_MASK,
        ATSIW_SEL_WAKE_EN,
        ATSIW_SEL_ALARM_0,
        ATSIW_SEL_ALARM_1,
        ATSIW_SEL_PERIOD0,
        ATSIW_SEL_PERIOD1,
        ATSIW_SEL_CLOCK
    } atsiw_sel_type;

endpackage

// ===== src/atsiw_regs.svh
// Purpose: Register offsets, field positions and reset values
// Assumes: Byte addresses on a 32-bit register bus
// Notes:   Definitions only
`ifndef ATSIW_REGS_SVH
`define ATSIW_REGS_SVH

// ----------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------
`define ATSIW_OFF_CONTROL    8'h00
`define ATSIW_OFF_COUNTER    8'h04
`define ATSIW_OFF_STATUS     8'h08
`define ATSIW_OFF_STAT_CLR   8'h0C
`define ATSIW_OFF_IRQ_SET    8'h10
`define ATSIW_OFF_IRQ_CLR    8'h14
`define ATSIW_OFF_IRQ_MASK   8'h18
`define ATSIW_OFF_WAKE_EN    8'h1C
`define ATSIW_OFF_ALARM_0    8'h20
`define ATSIW_OFF_ALARM_1    8'h24
`define ATSIW_OFF_PERIOD0    8'h30
`define ATSIW_OFF_PERIOD1    8'h34
`define ATSIW_OFF_CLOCK      8'h40

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ATSIW_BIT_OVERFLOW   0
`define ATSIW_BIT_ALARM_0    8
`define ATSIW_BIT_PER_0      16
`define ATSIW_BIT_BUSY       24
`define ATSIW_BIT_READY      25
`define ATSIW_BIT_CLK_BUSY   28
`define ATSIW_BIT_CLKREADY   29
`define ATSIW_BIT_CLR_ALARM  8
`define ATSIW_BIT_CLK_EN     0
`define ATSIW_TAP_SEL_W      5

// ----------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------
`define ATSIW_RESET_VALUE    32'h0000_0000
`define ATSIW_FLAG_MASK      32'h2203_0301
`define ATSIW_WAKE_MASK      32'h0003_0301
`define ATSIW_CTRL_MASK      32'h0000_0300
`define ATSIW_RESP_OKAY      2'h0
`define ATSIW_RESP_SLVERR    2'h2

`endif

// ===== src/atsiw_timer_status.sv
// Purpose: Status, interrupt mask, wake and compare part of a timer
// Assumes: Counter, prescaler and busy inputs already on aclk
// Notes:   AXI4-Lite slave, one write and one read at a time
//
// Function
// R1: Clock busy falling sets clock ready flag
// R2: Clock enable write holds clock busy until done
// R3: Sync busy falling sets timer ready flag
// R4: Busy discards writes to synchronised registers
// R5: Busy reads wake, alarm, interval as zero
// R6: Selected prescaler bit rising sets periodic flag
// R7: Counter equal to alarm sets alarm flag
// R8: Counter overflow sets sticky overflow flag
// R9: Status clear ones clear flags; zeros ignored
// R10: Enable-set ones set mask bits
// R11: Enable-clear ones clear mask bits
// R12: Mask register readable, resets to zero
// R13: Enabled periodic edge requests a wakeup
// R14: Enabled alarm match requests a wakeup
// R15: Enabled overflow requests a wakeup
// R16: Two read/write alarm values compared with counter
// R17: Interval select picks periodic prescaler tap
// R18: Counter value readable, zero while busy
// R19: Clear-on-alarm bit makes match clear counter
// R20: Shutdown wakeup resets mask only
// R21: Software checks busy before synchronised writes
// R22: Interrupt high when flag and mask coincide
// R23: Wake request is gated OR, mask independent
`timescale 1ns/10ps
`include "atsiw_regs.svh"
`default_nettype none
module atsiw_timer_status #(
    parameter int PRESC_W = 32,
    parameter int ADDR_W  = 8
) (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // Write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // Write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // Write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // Read address
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // Read data
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Timer core side
    input  wire logic [31:0]       counter_value,
    input  wire logic [PRESC_W-1:0] prescaler_bits,
    input  wire logic              counter_overflow,
    input  wire logic              sync_busy,
    input  wire logic              clock_change_done,
    input  wire logic              shutdown_wake,
    // Requests
    output logic                   irq,
    output logic                   wake_request,
    output logic                   counter_clear,
    output logic                   prescaler_clock_enable
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic atsiw_pkg::atsiw_sel_type decode(
        input logic [ADDR_W-1:0] addr
    );
        logic [7:0] a;
        a = addr[7:0];
        unique case (a)
            `ATSIW_OFF_CONTROL:  decode = atsiw_pkg::ATSIW_SEL_CONTROL;
            `ATSIW_OFF_COUNTER:  decode = atsiw_pkg::ATSIW_SEL_COUNTER;
            `ATSIW_OFF_STATUS:   decode = atsiw_pkg::ATSIW_SEL_STATUS;
            `ATSIW_OFF_STAT_CLR: decode = atsiw_pkg::ATSIW_SEL_STAT_CLR;
            `ATSIW_OFF_IRQ_SET:  decode = atsiw_pkg::ATSIW_SEL_IRQ_SET;
            `ATSIW_OFF_IRQ_CLR:  decode = atsiw_pkg::ATSIW_SEL_IRQ_CLR;
            `ATSIW_OFF_IRQ_MASK: decode = atsiw_pkg::ATSIW_SEL_IRQ_MASK;
            `ATSIW_OFF_WAKE_EN:  decode = atsiw_pkg::ATSIW_SEL_WAKE_EN;
            `ATSIW_OFF_ALARM_0:  decode = atsiw_pkg::ATSIW_SEL_ALARM_0;
            `ATSIW_OFF_ALARM_1:  decode = atsiw_pkg::ATSIW_SEL_ALARM_1;
            `ATSIW_OFF_PERIOD0:  decode = atsiw_pkg::ATSIW_SEL_PERIOD0;
            `ATSIW_OFF_PERIOD1:  decode = atsiw_pkg::ATSIW_SEL_PERIOD1;
            `ATSIW_OFF_CLOCK:    decode = atsiw_pkg::ATSIW_SEL_CLOCK;
            default:             decode = atsiw_pkg::ATSIW_SEL_NONE;
        endcase
    endfunction

    function automatic logic [31:0] lanes(input logic [3:0] strb);
        lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic              aw_held_q;
    logic              w_held_q;
    logic              awready_q;
    logic              wready_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              wr_fire;
    logic [31:0]       wbits;
    logic [31:0]       wmask;
    atsiw_pkg::atsiw_sel_type wsel;
    logic              wr_open;

    assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
    assign wsel    = decode(awaddr_q);
    assign wmask   = lanes(wstrb_q);
    assign wbits   = wdata_q & wmask;
    // Synchronised registers drop writes while the core is busy
    assign wr_open = wr_fire && !sync_busy; // [R4]

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q <= 1'b0;
            awaddr_q  <= '0;
        end
        else if (s_axi_awvalid && awready_q)
        begin
            aw_held_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
        end
        else if (wr_fire)
            aw_held_q <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held_q <= 1'b0;
            wdata_q  <= '0;
            wstrb_q  <= '0;
        end
        else if (s_axi_wvalid && wready_q)
        begin
            w_held_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
        end
        else if (wr_fire)
            w_held_q <= 1'b0;
    end

    // Ready only while the holding slot is empty and no answer waits
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
        end
        else
        begin
            awready_q <= !(s_axi_awvalid && awready_q) && !aw_held_q
                         && !bvalid_q && !wr_fire;
            wready_q  <= !(s_axi_wvalid && wready_q) && !w_held_q
                         && !bvalid_q && !wr_fire;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_q <= 1'b0;
            bresp_q  <= `ATSIW_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_q <= 1'b1;
            bresp_q  <= (wsel == atsiw_pkg::ATSIW_SEL_NONE)
                        ? `ATSIW_RESP_SLVERR : `ATSIW_RESP_OKAY;
        end
        else if (s_axi_bready)
            bvalid_q <= 1'b0;
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    logic [31:0] ctrl_q;
    logic [31:0] wake_en_q;
    logic [31:0] alarm_q [2];
    logic [`ATSIW_TAP_SEL_W-1:0] tap_sel_q [2];
    logic [31:0] mask_q;
    logic        clk_en_q;
    logic        clk_busy_q;
    logic        clk_wr;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_q    <= `ATSIW_RESET_VALUE;
            wake_en_q <= `ATSIW_RESET_VALUE;
        end
        else if (wr_open)
        begin
            if (wsel == atsiw_pkg::ATSIW_SEL_CONTROL)
                ctrl_q <= ((ctrl_q & ~wmask) | wbits) & `ATSIW_CTRL_MASK;
            if (wsel == atsiw_pkg::ATSIW_SEL_WAKE_EN)
                wake_en_q <= ((wake_en_q & ~wmask) | wbits)
                             & `ATSIW_WAKE_MASK;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_chan
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    alarm_q[gi]   <= `ATSIW_RESET_VALUE;
                    tap_sel_q[gi] <= '0;
                end
                else if (wr_open)
                begin
                    if (wsel == (gi == 0 ? atsiw_pkg::ATSIW_SEL_ALARM_0
                                         : atsiw_pkg::ATSIW_SEL_ALARM_1))
                        alarm_q[gi] <= (alarm_q[gi] & ~wmask) | wbits; // [R16]
                    if (wsel == (gi == 0 ? atsiw_pkg::ATSIW_SEL_PERIOD0
                                         : atsiw_pkg::ATSIW_SEL_PERIOD1)
                        && wstrb_q[0])
                        tap_sel_q[gi] <= wdata_q[`ATSIW_TAP_SEL_W-1:0]; // [R17]
                end
            end
        end
    endgenerate

    // Shutdown wakeup drops the mask but keeps everything else
    always_ff @(posedge aclk)
    begin
        if (!aresetn || shutdown_wake) // [R12] [R20]
            mask_q <= `ATSIW_RESET_VALUE;
        else if (wr_fire && wsel == atsiw_pkg::ATSIW_SEL_IRQ_SET)
            mask_q <= mask_q | (wbits & `ATSIW_FLAG_MASK); // [R10]
        else if (wr_fire && wsel == atsiw_pkg::ATSIW_SEL_IRQ_CLR)
            mask_q <= mask_q & ~wbits; // [R11]
    end

    assign clk_wr = wr_fire && wsel == atsiw_pkg::ATSIW_SEL_CLOCK
                    && wstrb_q[0];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            clk_en_q   <= 1'b0;
            clk_busy_q <= 1'b0;
        end
        else
        begin
            if (clk_wr)
                clk_en_q <= wdata_q[`ATSIW_BIT_CLK_EN];
            // Write wins over a completion in the same cycle
            if (clk_wr)
                clk_busy_q <= 1'b1; // [R2]
            else if (clock_change_done)
                clk_busy_q <= 1'b0; // [R2]
        end
    end

    // ------------------------------------------------------------
    // Events and flags
    // ------------------------------------------------------------
    logic [5:0]  lvl;
    logic [5:0]  rise;
    logic [5:0]  fall;
    logic [1:0]  per_evt;
    logic [1:0]  alm_evt;
    logic [31:0] set_v;
    logic [31:0] clr_v;
    logic [31:0] flags_q;

    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_evt
            assign lvl[gi]     = prescaler_bits[tap_sel_q[gi]]; // [R6]
            assign lvl[gi + 2] = counter_value == alarm_q[gi]; // [R7]
        end
    endgenerate
    assign lvl[4]  = sync_busy;
    assign lvl[5]  = clk_busy_q;
    assign per_evt = rise[1:0];
    assign alm_evt = rise[3:2];

    atsiw_edge #(
        .W (6)
    ) u_edge (
        .aclk    (aclk),
        .aresetn (aresetn),
        .level   (lvl),
        .rise    (rise),
        .fall    (fall)
    );

    always_comb
    begin
        set_v = '0;
        set_v[`ATSIW_BIT_OVERFLOW] = counter_overflow; // [R8]
        set_v[`ATSIW_BIT_ALARM_0 +: 2] = alm_evt; // [R7]
        set_v[`ATSIW_BIT_PER_0 +: 2] = per_evt; // [R6]
        set_v[`ATSIW_BIT_READY] = fall[4]; // [R3]
        set_v[`ATSIW_BIT_CLKREADY] = fall[5]; // [R1]
    end

    assign clr_v = (wr_open && wsel == atsiw_pkg::ATSIW_SEL_STAT_CLR)
                   ? wbits & `ATSIW_FLAG_MASK : '0; // [R9]

    atsiw_flags #(
        .W (32)
    ) u_flags (
        .aclk    (aclk),
        .aresetn (aresetn),
        .set     (set_v),
        .clr     (clr_v),
        .flags   (flags_q)
    );

    // ------------------------------------------------------------
    // Requests
    // ------------------------------------------------------------
    logic irq_q;
    logic wake_q;
    logic cclr_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_q  <= 1'b0;
            wake_q <= 1'b0;
            cclr_q <= 1'b0;
        end
        else
        begin
            irq_q  <= |(flags_q & mask_q); // [R22]
            wake_q <= |(set_v & wake_en_q); // [R13] [R14] [R15] [R23]
            cclr_q <= |(alm_evt & ctrl_q[`ATSIW_BIT_CLR_ALARM +: 2]); // [R19]
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    logic        arready_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic [31:0] rd_v;
    logic [31:0] stat_v;
    logic        rd_zero;
    atsiw_pkg::atsiw_sel_type rsel;

    assign rsel = decode(s_axi_araddr);

    always_comb
    begin
        stat_v = flags_q;
        stat_v[`ATSIW_BIT_BUSY] = sync_busy;
        stat_v[`ATSIW_BIT_CLK_BUSY] = clk_busy_q;
        rd_zero = 1'b0;
        unique case (rsel)
            atsiw_pkg::ATSIW_SEL_CONTROL:  rd_v = ctrl_q;
            atsiw_pkg::ATSIW_SEL_COUNTER:  rd_v = counter_value; // [R18]
            atsiw_pkg::ATSIW_SEL_STATUS:   rd_v = stat_v;
            atsiw_pkg::ATSIW_SEL_IRQ_MASK: rd_v = mask_q; // [R12]
            atsiw_pkg::ATSIW_SEL_WAKE_EN:  rd_v = wake_en_q;
            atsiw_pkg::ATSIW_SEL_ALARM_0:  rd_v = alarm_q[0];
            atsiw_pkg::ATSIW_SEL_ALARM_1:  rd_v = alarm_q[1];
            atsiw_pkg::ATSIW_SEL_PERIOD0:  rd_v = 32'(tap_sel_q[0]);
            atsiw_pkg::ATSIW_SEL_PERIOD1:  rd_v = 32'(tap_sel_q[1]);
            atsiw_pkg::ATSIW_SEL_CLOCK:    rd_v = {31'h0, clk_en_q};
            default:                       rd_v = '0;
        endcase
        unique case (rsel)
            atsiw_pkg::ATSIW_SEL_CONTROL, atsiw_pkg::ATSIW_SEL_COUNTER,
            atsiw_pkg::ATSIW_SEL_WAKE_EN, atsiw_pkg::ATSIW_SEL_ALARM_0,
            atsiw_pkg::ATSIW_SEL_ALARM_1, atsiw_pkg::ATSIW_SEL_PERIOD0,
            atsiw_pkg::ATSIW_SEL_PERIOD1: rd_zero = sync_busy; // [R5]
            default:                      rd_zero = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= `ATSIW_RESP_OKAY;
        end
        else if (s_axi_arvalid && arready_q)
        begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rd_zero ? '0 : rd_v; // [R5] [R18]
            rresp_q   <= (rsel == atsiw_pkg::ATSIW_SEL_NONE)
                         ? `ATSIW_RESP_SLVERR : `ATSIW_RESP_OKAY;
        end
        else if (rvalid_q && s_axi_rready)
            rvalid_q <= 1'b0;
        else if (!rvalid_q)
            arready_q <= 1'b1;
    end

    assign s_axi_awready          = awready_q;
    assign s_axi_wready           = wready_q;
    assign s_axi_bvalid           = bvalid_q;
    assign s_axi_bresp            = bresp_q;
    assign s_axi_arready          = arready_q;
    assign s_axi_rvalid           = rvalid_q;
    assign s_axi_rdata            = rdata_q;
    assign s_axi_rresp            = rresp_q;
    assign irq                    = irq_q;
    assign wake_request           = wake_q;
    assign counter_clear          = cclr_q;
    assign prescaler_clock_enable = clk_en_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_busy_write(atsiw_pkg::atsiw_sel_type s);
        wr_fire && sync_busy && wsel == s;
    endsequence

    AST_CLOCK_READY_SET: assert property ($fell(clk_busy_q) // [R1]
        |=> flags_q[29])
        else $error("clock ready not set");
    AST_CLOCK_BUSY: assert property (clk_wr // [R2]
        || (clk_busy_q && !clock_change_done) |=> clk_busy_q)
        else $error("clock busy not held");
    AST_READY_SET: assert property ($fell(sync_busy) |=> flags_q[25]) // [R3]
        else $error("ready not set on busy fall");
    AST_DISCARD_WAKE: assert property // [R4]
        (s_busy_write(atsiw_pkg::ATSIW_SEL_WAKE_EN) |=> $stable(wake_en_q))
        else $error("busy write changed wake enable");
    AST_READ_ZERO: assert property (s_axi_arvalid && arready_q // [R5]
        && sync_busy && rsel == atsiw_pkg::ATSIW_SEL_ALARM_0
        |=> rvalid_q && rdata_q == 0)
        else $error("busy read not zero");
    AST_PERIODIC: assert property (per_evt[0] |=> flags_q[16]) // [R6]
        else $error("periodic flag missing");
    AST_ALARM: assert property (|alm_evt // [R7]
        |=> (flags_q[9:8] & $past(alm_evt)) == $past(alm_evt))
        else $error("alarm flag missing");
    AST_OVERFLOW: assert property (counter_overflow // [R8]
        |=> flags_q[0])
        else $error("overflow flag missing");
    AST_MASK_SHUTDOWN: assert property (shutdown_wake |=> mask_q == 0) // [R20]
        else $error("mask kept across shutdown wake");
    AST_IRQ: assert property (|(flags_q & mask_q) |=> irq_q) // [R22]
        else $error("interrupt not raised");
    AST_WAKE_OVERFLOW: assert property (counter_overflow // [R15]
        && wake_en_q[0]
        |=> wake_q ##1 (!wake_q || $past(|(set_v & wake_en_q))))
        else $error("overflow wake wrong");

endmodule
`default_nettype wire

// ===== test/atsiw_timer_status_bench.sv
// Purpose: Bus-level bench for the timer status block
// Assumes: Event inputs are driven on aclk, one edge of flag latency
// Notes:   Bus tasks wait on handshakes; only the timeout ends a wait
`timescale 1ns/10ps
`default_nettype none
module atsiw_timer_status_bench;
    // ----------------------------------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------------------------------
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic [31:0] cnt = 32'h0000_0000;
    logic [31:0] presc = 32'h0000_0000;
    logic        wrap = 1'b0;
    logic        busy = 1'b0;
    logic        clk_done = 1'b0;
    logic        shut = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        irq, wake, cclr, pce;
    logic [1:0]  bresp, rresp, rresp_q, bresp_q;
    logic [31:0] rdata, rd_q;
    int          mismatches = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          wakes = 0;
    int          clears = 0;

    always #2 aclk = ~aclk;

    atsiw_timer_status uut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .counter_value(cnt), .prescaler_bits(presc),
        .counter_overflow(wrap), .sync_busy(busy),
        .clock_change_done(clk_done), .shutdown_wake(shut),
        .irq(irq), .wake_request(wake), .counter_clear(cclr),
        .prescaler_clock_enable(pce)
    );

    // ----------------------------------------------------------------
    // Pulse counters and timeout
    // ----------------------------------------------------------------
    always @(posedge aclk)
    begin
        cycles = cycles + 1;
        if (wake === 1'b1) wakes = wakes + 1;
        if (cclr === 1'b1) clears = clears + 1;
        if (cycles == 5000)
        begin
            mismatches = mismatches + 1;
            stop_test();
        end
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] e, g);
        tests_run = tests_run + 1;
        if (g !== e)
        begin
            mismatches = mismatches + 1;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    // Address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bresp_q = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd_q = rdata;
        rresp_q = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic stop_test();
        if (mismatches == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(8'h18); chk("mask", 32'h0, rd_q);
        wr(8'h10, 32'h1); wr(8'h14, 32'h0); rd(8'h18);
        chk("mask", 32'h1, rd_q);
        wr(8'h1C, 32'h1);
        wrap <= 1'b1;
        @(posedge aclk);
        wrap <= 1'b0;
        repeat (3) @(posedge aclk);
        chk("irq", 32'h1, {31'h0, irq});
        chk("wakes", 32'h1, wakes);
        rd(8'h08); chk("status", 32'h1, rd_q);
        wr(8'h0C, 32'h1); rd(8'h08);
        chk("status", 32'h0, rd_q);
        chk("irq", 32'h0, {31'h0, irq});
        wr(8'h14, 32'h1); rd(8'h18);
        chk("mask", 32'h0, rd_q);
        // Alarm with clear-on-alarm; overflow wake now off
        wr(8'h20, 32'hA5A5_0005); wr(8'h1C, 32'h100); wr(8'h00, 32'h100);
        rd(8'h20); chk("alarm_0", 32'hA5A5_0005, rd_q);
        cnt <= 32'hA5A5_0005;
        repeat (3) @(posedge aclk);
        rd(8'h08); chk("status", 32'h100, rd_q);
        chk("wakes", 32'h2, wakes);
        chk("clears", 32'h1, clears);
        wr(8'h0C, 32'h100); wr(8'h30, 32'h3); wr(8'h1C, 32'h1_0000);
        presc <= 32'h10;
        repeat (3) @(posedge aclk);
        rd(8'h08); chk("status", 32'h0, rd_q);
        presc <= 32'h18;
        repeat (3) @(posedge aclk);
        rd(8'h08); chk("status", 32'h1_0000, rd_q);
        chk("wakes", 32'h3, wakes);
        // Busy drops writes and hides contents
        busy <= 1'b1;
        wr(8'h1C, 32'h0); rd(8'h1C);
        chk("wake_en", 32'h0, rd_q);
        rd(8'h04); chk("counter", 32'h0, rd_q);
        rd(8'h20); chk("alarm_0", 32'h0, rd_q);
        busy <= 1'b0;
        rd(8'h1C); chk("wake_en", 32'h1_0000, rd_q);
        rd(8'h04); chk("counter", 32'hA5A5_0005, rd_q);
        rd(8'h08); chk("status", 32'h0201_0000, rd_q);
        wr(8'h40, 32'h1); rd(8'h08);
        chk("status", 32'h1201_0000, rd_q);
        chk("clk_en", 32'h1, {31'h0, pce});
        clk_done <= 1'b1;
        @(posedge aclk);
        clk_done <= 1'b0;
        @(posedge aclk);
        rd(8'h08); chk("status", 32'h2201_0000, rd_q);
        wr(8'h10, 32'h2000_0000);
        shut <= 1'b1;
        @(posedge aclk);
        shut <= 1'b0;
        rd(8'h18); chk("mask", 32'h0, rd_q);
        rd(8'h1C); chk("wake_en", 32'h1_0000, rd_q);
        rd(8'h60); chk("resp", 32'h2, {30'h0, rresp_q});
        wr(8'h60, 32'h0); chk("bresp", 32'h2, {30'h0, bresp_q});
        stop_test();
    end
endmodule
`default_nettype wire
